// file: shared/cmd_select_cfg.svh
/*
 * constants for the motor command selection block: parameter codes,
 * ranges, reset values and timing counts.
 * assumes a 20 MHz clock.
 */
`ifndef CMD_SELECT_CFG_SVH
`define CMD_SELECT_CFG_SVH

// parameter codes on the configuration port
`define PAR_SHAPING 8'h0d
`define PAR_PRIORITY 8'h07
`define PAR_FALLBACK 8'h0e
`define PAR_ECHO 8'h09
`define PAR_STORAGE 8'h00
`define PAR_BITRATE 8'h0a
`define PAR_WATCHDOG 8'h08
`define PAR_PRINTPORT 8'h5e
`define PAR_RADIO_CTR 8'h53
`define PAR_RADIO_DB 8'h54
`define PAR_RADIO_LIN 8'h55
`define PAR_RADIO_MAX 8'h52
`define PAR_RADIO_MIN 8'h51

// ranges
`define CURVE_MAX 8'h06
`define PRIO_SRC_MAX 8'h04
`define FALLBACK_MIN 16'hfc18
`define FALLBACK_HOLD 16'h03e9
`define BITRATE_MAX 8'h09
`define BITRATE_INV_BASE 8'h05
`define WATCHDOG_MAX 16'hfde8
`define PRINTPORT_MAX 8'h02
`define RADIO_RAW_MAX 16'h0400
`define RADIO_DB_MAX 8'h32

// reset values
`define RST_WATCHDOG 16'h03e8
`define RST_PRIO0 8'h00
`define RST_PRIO1 8'h01
`define RST_PRIO2 8'h04
`define RST_PRIO3 8'h04

// one millisecond of clock cycles
`define CLK_HZ 20000000
`define MS_CYCLES (`CLK_HZ / 1000)
`define MS_CYCLES_W 15
`endif

// file: shared/cmd_select_pkg.sv
/*
 * types for the motor command selection block.
 * assumes cmd_select_cfg.svh for all numeric constants.
 */
package cmd_select_pkg;

    typedef enum logic [1:0] {
        ORIGIN_RS232 = 2'b00,
        ORIGIN_USB = 2'b01,
        ORIGIN_CAN = 2'b10,
        ORIGIN_SCRIPT = 2'b11
    } origin_e;

    typedef enum logic [1:0] {
        FLASH_IDLE = 2'b00,
        FLASH_LOAD = 2'b01,
        FLASH_SAVE = 2'b10
    } flash_state_e;

    // one parameter write or read request
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] index;
        logic [15:0] value;
        origin_e origin;
    } cfg_req_s;

    // one command per source per motor channel
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } source_cmd_s;

endpackage : cmd_select_pkg

// file: verilog/cmd_select.sv
/*
 * motor command selection and conditioning with its configuration store.
 * assumes requests come from a command parser on the same clock, one at a
 * time, and a flash word port answering with one-cycle acknowledge.
 */
`include "cmd_select_cfg.svh"
module cmd_select (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire cmd_select_pkg::cfg_req_s cfg_req_i,
    input wire logic flash_save_i,
    input wire logic realtime_cmd_i,
    input wire logic rx_char_serial_i,
    input wire logic rx_char_usb_i,
    input wire cmd_select_pkg::source_cmd_s [1:0] serial_cmd_i,
    input wire cmd_select_pkg::source_cmd_s [1:0] pulse_cmd_i,
    input wire cmd_select_pkg::source_cmd_s [1:0] analog_cmd_i,
    input wire logic [1:0] radio_valid_i,
    input wire logic [31:0] radio_raw_i,
    input wire logic [15:0] flash_rdata_i,
    input wire logic flash_ack_i,
    output logic [15:0] cfg_rdata_o,
    output logic cfg_ack_o,
    output logic cfg_reject_o,
    output logic [31:0] motor_cmd_o,
    output logic [1:0] hold_position_o,
    output logic echo_enable_o,
    output logic [2:0] bit_rate_sel_o,
    output logic tx_invert_o,
    output logic [1:0] print_port_o,
    output logic watchdog_expired_o,
    output logic flash_req_o,
    output logic flash_we_o,
    output logic [4:0] flash_addr_o,
    output logic [15:0] flash_wdata_o,
    output logic storage_ready_o
);

    // configuration store
    logic [7:0] curve_q [2];
    logic [7:0] prio_q [4];
    logic [15:0] fallback_q [2];
    logic [7:0] echo_q;
    logic [7:0] bitrate_q;
    logic [15:0] wd_q;
    logic [7:0] printsel_q;
    logic [15:0] rctr_q [2];
    logic [7:0] rdb_q [2];
    logic [7:0] rlin_q [2];
    logic [15:0] rmax_q [2];
    logic [15:0] rmin_q [2];
    logic [15:0] store_q [32];
    logic [15:0] rdata_q;
    logic ack_q;
    logic rej_q;
    cmd_select_pkg::flash_state_e fstate_q;
    logic [4:0] faddr_q;
    logic ready_q;
    logic [`MS_CYCLES_W-1:0] ms_cnt_q;
    logic [15:0] wd_cnt_q;
    logic expired_q;
    logic last_usb_q;
    logic [1:0] hold_q;
    logic [31:0] motor_q;

    // shaping curve: x is magnitude 0..1000, curves 1..3 blend x toward x^2/1000, curves 4..6 bend x away from it
    function automatic logic [15:0] shape(input logic [7:0] curve, input logic [15:0] cmd);
        logic neg;
        logic [15:0] mag;
        logic [31:0] sq;
        logic [15:0] bend;
        logic [15:0] res;
        logic [1:0] k;
        neg = cmd[15];
        mag = neg ? 16'(-cmd) : cmd;
        if (mag > 16'h03e8)
        begin
            mag = 16'h03e8;
        end
        sq = (32'(mag) * 32'(mag)) / 32'h0000_03e8;
        bend = 16'(mag - sq[15:0]);                  // x - x^2, zero at both ends
        k = (curve > 8'h03) ? 2'(curve - 8'h03) : curve[1:0];
        res = mag;
        if (curve >= 8'h01 && curve <= 8'h03)
        begin
            res = 16'(mag - 16'((32'(bend) * 32'(k)) / 32'h3));
        end
        else if (curve >= 8'h04 && curve <= 8'h06)
        begin
            res = 16'(mag + 16'((32'(bend) * 32'(k)) / 32'h3));
        end
        shape = neg ? 16'(-res) : res;
    endfunction : shape

    // radio conversion: min/ctr/max to -1000/0/+1000 with deadband
    function automatic logic [16:0] radio_conv(input logic [15:0] raw, input logic [15:0] lo,
        input logic [15:0] ctr, input logic [15:0] hi, input logic [7:0] db);
        logic [31:0] span;
        logic [31:0] off;
        logic [31:0] band;
        logic [31:0] v;
        logic ok;
        ok = 1'b1;
        if (raw >= ctr)
        begin
            span = 32'(hi - ctr);
            off = 32'(raw - ctr);
        end
        else
        begin
            span = 32'(ctr - lo);
            off = 32'(ctr - raw);
        end
        band = (span * 32'(db)) / 32'd100;
        if (off <= band || span <= band)
        begin
            v = 32'h0;
        end
        else
        begin
            v = ((off - band) * 32'd1000) / (span - band);
            if (v > 32'd1000)
            begin
                v = 32'd1000;
            end
        end
        radio_conv = {ok, (raw >= ctr) ? v[15:0] : 16'(-v[15:0])};
    endfunction : radio_conv

    // range check of writes
    wire cmd_select_pkg::cfg_req_s rq = cfg_req_i;
    wire [15:0] val = rq.value;
    wire ch2_ok = (rq.index == 8'h01) || (rq.index == 8'h02);
    wire ch2_all = ch2_ok || (rq.index == 8'h00);
    wire ch_sel = (rq.index == 8'h02);
    wire signed [15:0] sval = val;
    wire wr = rq.valid && rq.write;
    wire rd = rq.valid && !rq.write;
    wire from_host_side = (rq.origin == cmd_select_pkg::ORIGIN_USB)
        || (rq.origin == cmd_select_pkg::ORIGIN_SCRIPT);
    wire range_ok =
        (rq.code == `PAR_SHAPING) ? ch2_all && val <= 16'(`CURVE_MAX) :
        (rq.code == `PAR_PRIORITY) ? rq.index >= 8'h01 && rq.index <= 8'h04
            && val <= 16'(`PRIO_SRC_MAX) :
        (rq.code == `PAR_FALLBACK) ? ch2_all && sval >= $signed(`FALLBACK_MIN)
            && sval <= $signed(`FALLBACK_HOLD) :
        (rq.code == `PAR_ECHO) ? val <= 16'h0001 :
        (rq.code == `PAR_STORAGE) ? rq.index <= 8'h20 :
        (rq.code == `PAR_BITRATE) ? val <= 16'(`BITRATE_MAX) && from_host_side :
        (rq.code == `PAR_WATCHDOG) ? val <= `WATCHDOG_MAX :
        (rq.code == `PAR_PRINTPORT) ? val <= 16'(`PRINTPORT_MAX) :
        (rq.code == `PAR_RADIO_DB) ? ch2_all && val <= 16'(`RADIO_DB_MAX) :
        (rq.code == `PAR_RADIO_LIN) ? ch2_all && val <= 16'(`CURVE_MAX) :
        (rq.code == `PAR_RADIO_CTR || rq.code == `PAR_RADIO_MAX
            || rq.code == `PAR_RADIO_MIN) ? ch2_all && val <= `RADIO_RAW_MAX : 1'b0;
    wire do_wr = wr && range_ok && ready_q;
    wire [1:0] ch_hit = (rq.index == 8'h00) ? 2'b11 : (ch_sel ? 2'b10 : 2'b01);

    // read mux
    wire [15:0] read_val =
        (rq.code == `PAR_SHAPING) ? {8'h0, curve_q[ch_sel]} :
        (rq.code == `PAR_PRIORITY) ? {8'h0, prio_q[2'(rq.index - 8'h01)]} :
        (rq.code == `PAR_FALLBACK) ? fallback_q[ch_sel] :
        (rq.code == `PAR_ECHO) ? {8'h0, echo_q} :
        (rq.code == `PAR_STORAGE) ? store_q[5'(rq.index - 8'h01)] :
        (rq.code == `PAR_BITRATE) ? {8'h0, bitrate_q} :
        (rq.code == `PAR_WATCHDOG) ? wd_q :
        (rq.code == `PAR_PRINTPORT) ? {8'h0, printsel_q} :
        (rq.code == `PAR_RADIO_CTR) ? rctr_q[ch_sel] :
        (rq.code == `PAR_RADIO_DB) ? {8'h0, rdb_q[ch_sel]} :
        (rq.code == `PAR_RADIO_LIN) ? {8'h0, rlin_q[ch_sel]} :
        (rq.code == `PAR_RADIO_MAX) ? rmax_q[ch_sel] :
        (rq.code == `PAR_RADIO_MIN) ? rmin_q[ch_sel] : 16'h0;
    wire rd_idx_ok = (rq.code == `PAR_PRIORITY) ? rq.index >= 8'h01 && rq.index <= 8'h04 :
        (rq.code == `PAR_STORAGE) ? rq.index >= 8'h01 && rq.index <= 8'h20 : ch2_all;
    wire rd_ok = rd && rd_idx_ok && ready_q;

    // single-channel and global settings
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            echo_q <= 8'h00;
            bitrate_q <= 8'h00;
            wd_q <= `RST_WATCHDOG;
            printsel_q <= 8'h00;
            prio_q[0] <= `RST_PRIO0;
            prio_q[1] <= `RST_PRIO1;
            prio_q[2] <= `RST_PRIO2;
            prio_q[3] <= `RST_PRIO3;
        end
        else if (do_wr)
        begin
            if (rq.code == `PAR_ECHO) echo_q <= val[7:0];
            if (rq.code == `PAR_BITRATE) bitrate_q <= val[7:0];
            if (rq.code == `PAR_WATCHDOG) wd_q <= val;
            if (rq.code == `PAR_PRINTPORT) printsel_q <= val[7:0];
            if (rq.code == `PAR_PRIORITY) prio_q[2'(rq.index - 8'h01)] <= val[7:0];
        end
    end

    // per-channel settings
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        always_ff @(posedge clock_i)
        begin
            if (sys_rst_i)
            begin
                curve_q[c] <= 8'h00;
                fallback_q[c] <= 16'h0000;
                rctr_q[c] <= 16'h0000;
                rdb_q[c] <= 8'h00;
                rlin_q[c] <= 8'h00;
                rmax_q[c] <= 16'h0000;
                rmin_q[c] <= 16'h0000;
            end
            else if (do_wr && ch_hit[c])
            begin
                if (rq.code == `PAR_SHAPING) curve_q[c] <= val[7:0];
                if (rq.code == `PAR_FALLBACK) fallback_q[c] <= val;
                if (rq.code == `PAR_RADIO_CTR) rctr_q[c] <= val;
                if (rq.code == `PAR_RADIO_DB) rdb_q[c] <= val[7:0];
                if (rq.code == `PAR_RADIO_LIN) rlin_q[c] <= val[7:0];
                if (rq.code == `PAR_RADIO_MAX) rmax_q[c] <= val;
                if (rq.code == `PAR_RADIO_MIN) rmin_q[c] <= val;
            end
        end
    end

    // user storage ram with flash load at power up and save on request
    wire st_wr = do_wr && rq.code == `PAR_STORAGE;
    for (genvar w = 0; w < 32; w++)
    begin : g_store
        always_ff @(posedge clock_i)
        begin
            if (sys_rst_i)
            begin
                store_q[w] <= 16'h0000;
            end
            else if (fstate_q == cmd_select_pkg::FLASH_LOAD && flash_ack_i
                && faddr_q == 5'(w))
            begin
                store_q[w] <= flash_rdata_i;
            end
            else if (st_wr && (rq.index == 8'h00 || 5'(rq.index - 8'h01) == 5'(w)))
            begin
                store_q[w] <= val;
            end
        end
    end

    // flash sequencer: load after reset, save only on command
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            fstate_q <= cmd_select_pkg::FLASH_LOAD;
            faddr_q <= 5'h00;
            ready_q <= 1'b0;
        end
        else
        begin
            case (fstate_q)
                cmd_select_pkg::FLASH_IDLE:
                begin
                    ready_q <= 1'b1;
                    if (flash_save_i)
                    begin
                        fstate_q <= cmd_select_pkg::FLASH_SAVE;
                        ready_q <= 1'b0;
                    end
                end
                cmd_select_pkg::FLASH_LOAD, cmd_select_pkg::FLASH_SAVE:
                begin
                    if (flash_ack_i)
                    begin
                        faddr_q <= 5'(faddr_q + 5'h01);
                        if (faddr_q == 5'h1f)
                        begin
                            fstate_q <= cmd_select_pkg::FLASH_IDLE;
                        end
                    end
                end
                default: fstate_q <= cmd_select_pkg::FLASH_IDLE;
            endcase
        end
    end

    // serial watchdog in milliseconds, restarted by realtime commands only
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || realtime_cmd_i)
        begin
            ms_cnt_q <= '0;
            wd_cnt_q <= 16'h0000;
            expired_q <= 1'b0;
        end
        else if (wd_q == 16'h0000)
        begin
            expired_q <= 1'b0;
            wd_cnt_q <= 16'h0000;
        end
        else if (ms_cnt_q == `MS_CYCLES_W'(`MS_CYCLES - 1))
        begin
            ms_cnt_q <= '0;
            if (wd_cnt_q >= 16'(wd_q - 16'h0001))
            begin
                expired_q <= 1'b1;
            end
            else
            begin
                wd_cnt_q <= 16'(wd_cnt_q + 16'h0001);
            end
        end
        else
        begin
            ms_cnt_q <= `MS_CYCLES_W'(ms_cnt_q + 1'b1);
        end
    end

    // last port with a valid character, for print routing
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            last_usb_q <= 1'b0;
        else if (rx_char_usb_i)
            last_usb_q <= 1'b1;
        else if (rx_char_serial_i)
            last_usb_q <= 1'b0;
    end

    // priority selection and shaping per motor channel
    logic [15:0] sel_cmd [2];
    logic sel_ok [2];
    for (genvar c = 0; c < 2; c++)
    begin : g_mot
        wire [16:0] rconv = radio_conv(radio_raw_i[16*c +: 16], rmin_q[c], rctr_q[c],
            rmax_q[c], rdb_q[c]);
        wire [15:0] rval = shape(rlin_q[c], rconv[15:0]);
        // serial is one merged source, ordered by the parser
        wire ser_ok = serial_cmd_i[c].valid && !expired_q;
        always_comb
        begin
            sel_ok[c] = 1'b0;
            sel_cmd[c] = fallback_q[c];
            for (int p = 3; p >= 0; p--)
            begin
                case (prio_q[p])
                    8'h00: if (ser_ok) begin sel_ok[c] = 1'b1; sel_cmd[c] = serial_cmd_i[c].value; end
                    8'h01: if (pulse_cmd_i[c].valid) begin sel_ok[c] = 1'b1; sel_cmd[c] = pulse_cmd_i[c].value; end
                    8'h02: if (radio_valid_i[c]) begin sel_ok[c] = 1'b1; sel_cmd[c] = rval; end
                    8'h03: if (analog_cmd_i[c].valid) begin sel_ok[c] = 1'b1; sel_cmd[c] = analog_cmd_i[c].value; end
                    default: ;
                endcase
            end
        end
        wire hold = !sel_ok[c] && fallback_q[c] == `FALLBACK_HOLD;
        always_ff @(posedge clock_i)
        begin
            if (sys_rst_i)
            begin
                motor_q[16*c +: 16] <= 16'h0000;
                hold_q[c] <= 1'b0;
            end
            else
            begin
                hold_q[c] <= hold;
                motor_q[16*c +: 16] <= hold ? 16'h0000 : shape(curve_q[c], sel_cmd[c]);
            end
        end
    end

    // answer to configuration requests
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
            rej_q <= 1'b0;
        end
        else
        begin
            ack_q <= do_wr || rd_ok;
            rej_q <= rq.valid && !(do_wr || rd_ok);
            rdata_q <= rd_ok ? read_val : 16'h0000;
        end
    end

    assign cfg_rdata_o = rdata_q;
    assign cfg_ack_o = ack_q;
    assign cfg_reject_o = rej_q;
    assign motor_cmd_o = motor_q;
    assign hold_position_o = hold_q;
    assign echo_enable_o = (echo_q == 8'h00);
    assign bit_rate_sel_o = (bitrate_q >= `BITRATE_INV_BASE) ?
        3'(bitrate_q - `BITRATE_INV_BASE) : bitrate_q[2:0];
    assign tx_invert_o = (bitrate_q >= `BITRATE_INV_BASE);
    assign print_port_o = (printsel_q == 8'h00) ? {last_usb_q, !last_usb_q}
        : printsel_q[1:0];
    assign watchdog_expired_o = expired_q;
    assign flash_req_o = (fstate_q != cmd_select_pkg::FLASH_IDLE);
    assign flash_we_o = (fstate_q == cmd_select_pkg::FLASH_SAVE);
    assign flash_addr_o = faddr_q;
    assign flash_wdata_o = store_q[faddr_q];
    assign storage_ready_o = ready_q;

endmodule : cmd_select

// file: testbench/flash_model.sv
/* flash word store answering the storage port, ack every other cycle.
   assumes one clock shared with cmd_select. */
module flash_model (
    input wire logic clock_i,
    input wire logic flash_req_i,
    input wire logic flash_we_i,
    input wire logic [4:0] flash_addr_i,
    input wire logic [15:0] flash_wdata_i,
    output logic flash_ack_o,
    output logic [15:0] flash_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [32];
    // preset image loaded at power up
    initial
    begin
        for (int k = 0; k < 32; k++)
            mem[k] = 16'h0100 + 16'(k);
        flash_ack_o = 1'b0;
        flash_rdata_o = 16'h0000;
    end
    // slow answer; data line toggles outside an answer
    always @(posedge clock_i)
    begin
        flash_ack_o <= flash_req_i && !flash_ack_o;
        flash_rdata_o <= (flash_req_i && !flash_ack_o) ? mem[flash_addr_i] : ~flash_rdata_o;
        if (flash_req_i && flash_we_i && flash_ack_o)
            mem[flash_addr_i] <= flash_wdata_i;
    end
endmodule : flash_model

// file: testbench/cmd_select_checker.sv
/* port assertions for cmd_select.
   assumes bind into cmd_select, one clock domain. */
`include "cmd_select_cfg.svh"
module cmd_select_checker (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire cmd_select_pkg::cfg_req_s cfg_req_i,
    input wire logic flash_save_i,
    input wire logic realtime_cmd_i,
    input wire logic flash_ack_i,
    input wire logic cfg_ack_o,
    input wire logic cfg_reject_o,
    input wire logic [31:0] motor_cmd_o,
    input wire logic [1:0] hold_position_o,
    input wire logic echo_enable_o,
    input wire logic [2:0] bit_rate_sel_o,
    input wire logic tx_invert_o,
    input wire logic watchdog_expired_o,
    input wire logic flash_req_o,
    input wire logic flash_we_o,
    input wire logic [4:0] flash_addr_o,
    input wire logic storage_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // config port answers
    answer_once_a: assert property (cfg_req_i.valid |=> cfg_ack_o ^ cfg_reject_o)
        else $error("request not answered once");
    no_stray_a: assert property ((cfg_ack_o || cfg_reject_o) |-> $past(cfg_req_i.valid))
        else $error("answer without request");
    early_reject_a: assert property (cfg_req_i.valid && !storage_ready_o |=> cfg_reject_o)
        else $error("request before load accepted");
    rs232_rate_a: assert property (cfg_req_i.valid && cfg_req_i.write
        && cfg_req_i.code == `PAR_BITRATE && cfg_req_i.origin == cmd_select_pkg::ORIGIN_RS232
        |=> cfg_reject_o) else $error("rate change over rs232 accepted");
    // reset values checked through reset itself, then hold, rate range and realtime restart
    reset_state_a: assert property (disable iff (1'b0) sys_rst_i |=> echo_enable_o
        && bit_rate_sel_o == 3'h0 && !tx_invert_o && motor_cmd_o == 32'h0)
        else $error("bad reset state");
    hold_zero_a: assert property (hold_position_o[0] |-> motor_cmd_o[15:0] == 16'h0)
        else $error("hold with nonzero command");
    rate_range_a: assert property (bit_rate_sel_o <= 3'h4)
        else $error("rate select out of range");
    wdog_restart_a: assert property (realtime_cmd_i |=> !watchdog_expired_o)
        else $error("realtime did not clear expiry");
    // flash sequencing
    save_start_a: assert property (flash_save_i && storage_ready_o && !flash_req_o
        |=> flash_req_o && flash_we_o && flash_addr_o == 5'h00) else $error("save not started");
    addr_step_a: assert property (flash_req_o && flash_ack_i && flash_addr_o != 5'h1f
        |=> flash_req_o && flash_addr_o == $past(flash_addr_o) + 5'h01)
        else $error("flash address did not step");
    ready_rise_a: assert property (flash_req_o && !flash_we_o && flash_ack_i
        && flash_addr_o == 5'h1f |=> ##1 storage_ready_o) else $error("not ready after load");
endmodule : cmd_select_checker
bind cmd_select cmd_select_checker chk (.*);

// file: testbench/cmd_select_tb.sv
/* self-checking bench driving cmd_select config and command inputs.
   assumes flash_model on the flash port and the bound checker. */
`include "cmd_select_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module cmd_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    cmd_select_pkg::cfg_req_s req = '0;
    logic save = 1'b0;
    logic rt = 1'b0;
    logic rx_ser = 1'b0;
    logic rx_usb = 1'b0;
    cmd_select_pkg::source_cmd_s [1:0] ser_cmd = '0;
    cmd_select_pkg::source_cmd_s [1:0] pul_cmd = '0;
    logic [1:0] rv = 2'b00;
    logic [31:0] rraw = '0;
    logic [15:0] rdata, frdata, fwdata;
    logic ack, rej, fack, freq, fwe, wd_exp, ready, echo, inv;
    logic [31:0] motor;
    logic [1:0] hold, pport;
    logic [2:0] rate;
    logic [4:0] faddr;
    int failures = 0;
    int num_checks = 0;
    int n;
    // clock and instances
    always #25 clock_i = ~clock_i;
    flash_model fm (.clock_i(clock_i), .flash_req_i(freq), .flash_we_i(fwe),
        .flash_addr_i(faddr), .flash_wdata_i(fwdata), .flash_ack_o(fack), .flash_rdata_o(frdata));
    cmd_select uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cfg_req_i(req),
        .flash_save_i(save), .realtime_cmd_i(rt), .rx_char_serial_i(rx_ser),
        .rx_char_usb_i(rx_usb), .serial_cmd_i(ser_cmd), .pulse_cmd_i(pul_cmd),
        .analog_cmd_i('0), .radio_valid_i(rv), .radio_raw_i(rraw),
        .flash_rdata_i(frdata), .flash_ack_i(fack), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
        .cfg_reject_o(rej), .motor_cmd_o(motor), .hold_position_o(hold),
        .echo_enable_o(echo), .bit_rate_sel_o(rate), .tx_invert_o(inv),
        .print_port_o(pport), .watchdog_expired_o(wd_exp), .flash_req_o(freq),
        .flash_we_o(fwe), .flash_addr_o(faddr), .flash_wdata_o(fwdata),
        .storage_ready_o(ready));
    task automatic tick(input int c);
        repeat (c) @(posedge clock_i);
        #1;
    endtask : tick
    task automatic access(input logic w, input logic [7:0] c, input logic [7:0] i,
        input logic [15:0] v, input cmd_select_pkg::origin_e o, input logic ok,
        input logic [15:0] exp_rd);
        tick(1);
        req = '{1'b1, w, c, i, v, o};
        tick(1);
        req.valid = 1'b0;
        `CHK(ack, ok)
        `CHK(rej, !ok)
        if (ok && !w)
            `CHK(rdata, exp_rd)
    endtask : access
    task automatic wr(input logic [7:0] c, input logic [7:0] i, input logic [15:0] v,
        input logic ok);
        access(1'b1, c, i, v, cmd_select_pkg::ORIGIN_USB, ok, 16'h0);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [7:0] i, input logic [15:0] e);
        access(1'b0, c, i, 16'h0, cmd_select_pkg::ORIGIN_USB, 1'b1, e);
    endtask : rd
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // hang guard
    initial
    begin
        #4000000;
        failures++;
        end_sim();
    end
    // test sequence
    initial
    begin
        tick(12);
        sys_rst_i = 1'b0;
        wr(`PAR_ECHO, 8'h00, 16'h0001, 1'b0);
        n = 0;
        while (ready !== 1'b1 && n < 1000)
        begin
            tick(1);
            n++;
        end
        `CHK(ready, 1'b1)
        `CHK(echo, 1'b1)
        rd(`PAR_PRIORITY, 8'h01, 16'h0000);
        rd(`PAR_PRIORITY, 8'h02, 16'h0001);
        rd(`PAR_PRIORITY, 8'h03, 16'h0004);
        rd(`PAR_FALLBACK, 8'h01, 16'h0000);
        rd(`PAR_WATCHDOG, 8'h00, 16'h03e8);
        rd(`PAR_SHAPING, 8'h02, 16'h0000);
        rd(`PAR_PRINTPORT, 8'h00, 16'h0000);
        rd(`PAR_STORAGE, 8'h01, 16'h0100);
        rd(`PAR_STORAGE, 8'h20, 16'h011f);
        $display("test reset values done");
        wr(`PAR_STORAGE, 8'h00, 16'h5a5a, 1'b1);
        rd(`PAR_STORAGE, 8'h11, 16'h5a5a);
        access(1'b0, `PAR_STORAGE, 8'h00, 16'h0, cmd_select_pkg::ORIGIN_USB, 1'b0, 16'h0);
        wr(`PAR_STORAGE, 8'h21, 16'h1234, 1'b0);
        `CHK(fm.mem[31], 16'h011f)
        save = 1'b1;
        tick(1);
        save = 1'b0;
        tick(2);
        n = 0;
        while (freq === 1'b1 && n < 1000)
        begin
            tick(1);
            n++;
        end
        `CHK(freq, 1'b0)
        `CHK(fm.mem[31], 16'h5a5a)
        $display("test storage done");
        access(1'b1, `PAR_BITRATE, 8'h00, 16'h3, cmd_select_pkg::ORIGIN_RS232, 1'b0, 16'h0);
        access(1'b1, `PAR_BITRATE, 8'h00, 16'h3, cmd_select_pkg::ORIGIN_CAN, 1'b0, 16'h0);
        for (int k = 0; k < 10; k++)
        begin
            access(1'b1, `PAR_BITRATE, 8'h00, 16'(k), cmd_select_pkg::ORIGIN_SCRIPT, 1'b1, 16'h0);
            `CHK(rate, 3'(k % 5))
            `CHK(inv, k >= 5)
        end
        wr(`PAR_BITRATE, 8'h00, 16'h000a, 1'b0);
        wr(`PAR_ECHO, 8'h00, 16'h0001, 1'b1);
        `CHK(echo, 1'b0)
        wr(`PAR_ECHO, 8'h00, 16'h0002, 1'b0);
        rd(`PAR_ECHO, 8'h00, 16'h0001);
        wr(`PAR_PRINTPORT, 8'h00, 16'h0002, 1'b1);
        `CHK(pport, 2'h2)
        wr(`PAR_PRINTPORT, 8'h00, 16'h0000, 1'b1);
        rx_usb = 1'b1;
        tick(1);
        rx_usb = 1'b0;
        tick(2);
        `CHK(pport, 2'h2)
        rx_ser = 1'b1;
        tick(1);
        rx_ser = 1'b0;
        tick(2);
        `CHK(pport, 2'h1)
        $display("test port settings done");
        wr(`PAR_FALLBACK, 8'h01, 16'd500, 1'b1);
        tick(2);
        `CHK(motor[15:0], 16'd500)
        wr(`PAR_FALLBACK, 8'h01, 16'hfc17, 1'b0);
        wr(`PAR_FALLBACK, 8'h01, 16'h03e9, 1'b1);
        tick(2);
        `CHK(hold[0], 1'b1)
        wr(`PAR_FALLBACK, 8'h01, 16'h0000, 1'b1);
        ser_cmd[0] = {1'b1, 16'd500};
        pul_cmd[0] = {1'b1, 16'hff38};
        tick(2);
        `CHK(motor[15:0], 16'd500)
        wr(`PAR_SHAPING, 8'h01, 16'h0003, 1'b1);
        tick(2);
        `CHK(motor[15:0], 16'd250)
        wr(`PAR_SHAPING, 8'h01, 16'h0006, 1'b1);
        tick(2);
        `CHK(motor[15:0], 16'd750)
        wr(`PAR_SHAPING, 8'h01, 16'h0007, 1'b0);
        wr(`PAR_SHAPING, 8'h01, 16'h0000, 1'b1);
        wr(`PAR_PRIORITY, 8'h01, 16'h0001, 1'b1);
        tick(2);
        `CHK(motor[15:0], 16'hff38)
        wr(`PAR_PRIORITY, 8'h01, 16'h0005, 1'b0);
        wr(`PAR_RADIO_CTR, 8'h01, 16'h0200, 1'b1);
        wr(`PAR_RADIO_MAX, 8'h01, 16'h0400, 1'b1);
        wr(`PAR_RADIO_MAX, 8'h02, 16'h0401, 1'b0);
        wr(`PAR_PRIORITY, 8'h01, 16'h0002, 1'b1);
        rv = 2'b01;
        rraw = 32'h0000_0300;
        tick(2);
        `CHK(motor[15:0], 16'd500)
        wr(`PAR_RADIO_DB, 8'h01, 16'h0032, 1'b1);
        tick(2);
        `CHK(motor[15:0], 16'h0000)
        rraw = 32'h0000_0000;
        tick(2);
        `CHK(motor[15:0], 16'hfc18)
        wr(`PAR_PRIORITY, 8'h01, 16'h0000, 1'b1);
        $display("test command path done");
        wr(`PAR_WATCHDOG, 8'h00, 16'h0002, 1'b1);
        rt = 1'b1;
        tick(1);
        rt = 1'b0;
        n = 0;
        while (wd_exp !== 1'b1 && n < 50000)
        begin
            tick(1);
            n++;
        end
        `CHK(n >= 39990 && n <= 40010, 1'b1)
        tick(2);
        `CHK(motor[15:0], 16'hff38)
        rt = 1'b1;
        tick(1);
        rt = 1'b0;
        tick(2);
        `CHK(wd_exp, 1'b0)
        `CHK(motor[15:0], 16'd500)
        wr(`PAR_WATCHDOG, 8'h00, 16'h0001, 1'b1);
        tick(20010);
        `CHK(wd_exp, 1'b1)
        wr(`PAR_WATCHDOG, 8'h00, 16'h0000, 1'b1);
        tick(1);
        `CHK(wd_exp, 1'b0)
        $display("test watchdog done");
        end_sim();
    end
endmodule : cmd_select_tb
